// File: core/priority_interrupt_arbiter.sv
// priority interrupt arbiter: level select, vectoring, fast channels, wake and boot address
//
// Operation
// - many concurrent requests, exactly one winner presented at a time
// - request to core only when winner level is accepted at core level
// - service address presented together with the request
// - configuration and pending state reachable by software
// - 82 sources, each one of four levels, some hard-wired
// - per level, lowest numbered active request is selected
// - source zero wins within a level, source 81 loses
// - two fast channels divert a chosen source to own address
// - in wait or stop, pending request asks for clock restart
// - after reset release, drive initial fetch address to the core
// - normal address is vector base concatenated with vector number
// - level 2 winner matching a fast register uses fast address
// - nesting: request above current core level still forwarded
// - in low power, pin interrupts become low-level sensitive
`timescale 1ns/1ns
module priority_interrupt_arbiter
	import irq_arb_pkg::*;
#(
	parameter logic [ADDR_W-1:0] INIT_ADDR = INIT_ADDR_RST
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// request sources and pins
	input wire logic [NUM_SRC-1:0] irq_src,
	input wire logic ext_irq_pin_a_n,
	input wire logic ext_irq_pin_b_n,
	// configuration
	input wire logic [NUM_SRC-1:0] src_enable,
	input wire logic [NUM_SRC-1:0][LEVEL_W-1:0] src_level,
	input wire logic [BASE_W-1:0] vector_base,
	input wire fast_cfg_s fast_match_zero,
	input wire fast_cfg_s fast_match_one,
	input wire pin_cfg_s pin_cfg,
	// core side
	input wire logic [LEVEL_W-1:0] core_mask,
	input wire logic irq_ack,
	input wire logic [SRC_W-1:0] ack_num,
	input wire logic low_power,
	output logic core_irq_ff,
	output logic [ADDR_W-1:0] vec_addr_ff,
	output logic [SRC_W-1:0] vec_num_ff,
	output logic fast_hit_ff,
	output logic [NUM_SRC-1:0] pending_ff,
	// system integration unit and boot
	output logic wake_ff,
	output logic init_fetch_ff,
	output logic [ADDR_W-1:0] init_addr_ff
);
	// ==========================================================
	// level lookup
	function automatic logic [LEVEL_W-1:0] eff_level(input int idx,
			input logic [LEVEL_W-1:0] prog);
		eff_level = (idx < FIXED_COUNT) ? FIXED_LEVEL : prog;
	endfunction

	// ==========================================================
	// external pins
	logic pin_a_prev_ff;
	logic pin_b_prev_ff;
	logic edge_a_ff;
	logic edge_b_ff;
	logic nxt_edge_a;
	logic nxt_edge_b;
	wire fall_a = pin_a_prev_ff & ~ext_irq_pin_a_n;
	wire fall_b = pin_b_prev_ff & ~ext_irq_pin_b_n;
	wire ack_a = irq_ack && (ack_num == SRC_PIN_A);
	wire ack_b = irq_ack && (ack_num == SRC_PIN_B);
	// a fresh edge beats a same-cycle acknowledge
	assign nxt_edge_a = fall_a | (edge_a_ff & ~ack_a);
	assign nxt_edge_b = fall_b | (edge_b_ff & ~ack_b);
	// no clock in wait/stop to see edges, so fall back to level
	wire req_a = (pin_cfg.edge_a && !low_power) ? edge_a_ff : ~ext_irq_pin_a_n;
	wire req_b = (pin_cfg.edge_b && !low_power) ? edge_b_ff : ~ext_irq_pin_b_n;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_a_prev_ff <= 1'b1;
			pin_b_prev_ff <= 1'b1;
			edge_a_ff <= 1'b0;
			edge_b_ff <= 1'b0;
		end else begin
			pin_a_prev_ff <= ext_irq_pin_a_n;
			pin_b_prev_ff <= ext_irq_pin_b_n;
			edge_a_ff <= nxt_edge_a;
			edge_b_ff <= nxt_edge_b;
		end
	end

	// ==========================================================
	// per-level request vectors
	logic [NUM_SRC-1:0] pend_c;
	logic [3:0][NUM_SRC-1:0] lvl_pend_c;
	logic [3:0] lvl_found_c;
	logic [3:0][SRC_W-1:0] lvl_idx_c;

	always_comb begin
		pend_c = irq_src;
		pend_c[SRC_PIN_A] = req_a;
		pend_c[SRC_PIN_B] = req_b;
		pend_c = pend_c & src_enable;
	end

	for (genvar l = 0; l < 4; l++) begin : g_level
		for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
			assign lvl_pend_c[l][i] = pend_c[i] &&
				(eff_level(i, src_level[i]) == LEVEL_W'(l));
		end
		// lowest number wins inside a level
		lowest_index_encoder #(.N(NUM_SRC), .W(SRC_W)) u_enc (
			.req(lvl_pend_c[l]),
			.found(lvl_found_c[l]),
			.index(lvl_idx_c[l])
		);
	end

	// ==========================================================
	// winner and address selection
	wire any_found_c = |lvl_found_c;
	wire [LEVEL_W-1:0] win_level_c = lvl_found_c[3] ? 2'h3 :
		lvl_found_c[2] ? 2'h2 : lvl_found_c[1] ? 2'h1 : 2'h0;
	wire [SRC_W-1:0] win_idx_c = lvl_idx_c[win_level_c];
	// masked levels are those below the core's current level
	wire accept_c = any_found_c && (win_level_c >= core_mask);
	wire fast0_c = (win_level_c == FAST_LEVEL) && (win_idx_c == fast_match_zero.match);
	wire fast1_c = (win_level_c == FAST_LEVEL) && (win_idx_c == fast_match_one.match);
	wire [ADDR_W-1:0] norm_addr_c = {vector_base, win_idx_c};
	// channel zero checked first when both match the same source
	wire [ADDR_W-1:0] sel_addr_c = fast0_c ? {fast_match_zero.vec_high, fast_match_zero.vec_low} :
		fast1_c ? {fast_match_one.vec_high, fast_match_one.vec_low} : norm_addr_c;

	logic [LEVEL_W-1:0] win_level_ff;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			core_irq_ff <= 1'b0;
			vec_addr_ff <= ADDR_RST;
			vec_num_ff <= SRC_RST;
			fast_hit_ff <= 1'b0;
			win_level_ff <= LEVEL_RST;
			pending_ff <= '0;
			wake_ff <= 1'b0;
		end else begin
			core_irq_ff <= accept_c;
			vec_addr_ff <= sel_addr_c;
			vec_num_ff <= win_idx_c;
			fast_hit_ff <= accept_c && (fast0_c || fast1_c);
			win_level_ff <= win_level_c;
			pending_ff <= pend_c;
			wake_ff <= low_power && (|pend_c);
		end
	end

	// ==========================================================
	// initial fetch address after reset
	logic boot_done_ff;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			boot_done_ff <= 1'b0;
			init_fetch_ff <= 1'b0;
			init_addr_ff <= INIT_ADDR_RST;
		end else begin
			boot_done_ff <= 1'b1;
			init_fetch_ff <= !boot_done_ff;
			init_addr_ff <= INIT_ADDR;
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	wire [NUM_SRC-1:0] lower_mask_c = (NUM_SRC'(1) << win_idx_c) - NUM_SRC'(1);
	wire [3:0] above_mask_c = 4'(4'hE << win_level_c);

	core_req_gate_a: assert property (core_irq_ff |-> win_level_ff >= $past(core_mask))
		else $error("core request given below core level");
	no_lost_req_a: assert property (
		($past(any_found_c) && $past(win_level_c) >= $past(core_mask)) |-> core_irq_ff)
		else $error("acceptable request not forwarded");
	req_has_src_a: assert property (core_irq_ff |-> $past(any_found_c))
		else $error("core request without any pending source");
	lowest_wins_a: assert property (
		any_found_c |-> lvl_pend_c[win_level_c][win_idx_c] &&
		((lvl_pend_c[win_level_c] & lower_mask_c) == '0))
		else $error("winner is not lowest active source");
	top_level_a: assert property (any_found_c |-> ((lvl_found_c & above_mask_c) == 4'h0))
		else $error("a higher level was passed over");
	normal_vec_a: assert property (
		core_irq_ff && !fast_hit_ff |-> vec_addr_ff == {$past(vector_base), vec_num_ff})
		else $error("normal vector address wrong");
	fast_zero_first_a: assert property (
		fast_hit_ff && $past(fast0_c) |-> vec_addr_ff ==
		{$past(fast_match_zero.vec_high), $past(fast_match_zero.vec_low)})
		else $error("fast channel zero address not used");
	fast_level_a: assert property (fast_hit_ff |-> core_irq_ff && win_level_ff == FAST_LEVEL)
		else $error("fast vector outside level two");
	wake_req_a: assert property (low_power && (|pend_c) |=> wake_ff)
		else $error("no wake while request pending");
	pin_level_a: assert property (
		low_power && !ext_irq_pin_a_n |-> pend_c[SRC_PIN_A] || !src_enable[SRC_PIN_A])
		else $error("pin a not level sensitive in low power");
	pin_b_level_a: assert property (
		low_power && !ext_irq_pin_b_n |-> pend_c[SRC_PIN_B] || !src_enable[SRC_PIN_B])
		else $error("pin b not level sensitive in low power");
	edge_a_set_a: assert property (fall_a |=> edge_a_ff)
		else $error("falling edge on pin a not latched");
	edge_b_set_a: assert property (fall_b |=> edge_b_ff)
		else $error("falling edge on pin b not latched");
	init_once_a: assert property (init_fetch_ff |=> !init_fetch_ff [*8])
		else $error("initial fetch repeated");
	src_zero_a: assert property (
		lvl_pend_c[win_level_c][0] && any_found_c |-> win_idx_c == '0)
		else $error("source zero lost inside its level");

	fast_seen_c: cover property (fast_hit_ff);
	nest_seen_c: cover property (core_irq_ff && core_mask != 2'h0);
	wake_seen_c: cover property (wake_ff ##1 core_irq_ff);
	edge_seen_c: cover property (fall_a ##1 edge_a_ff);
endmodule

// File: core/irq_arb_pkg.sv
// shared constants and carriers for the priority interrupt arbiter
package irq_arb_pkg;
	// ==========================================================
	// sizes
	localparam int NUM_SRC = 82;
	localparam int SRC_W = 7;
	localparam int LEVEL_W = 2;
	localparam int ADDR_W = 21;
	localparam int BASE_W = ADDR_W - SRC_W;
	localparam int FAST_LO_W = 16;
	localparam int FAST_HI_W = ADDR_W - FAST_LO_W;

	// ==========================================================
	// fixed sources, fast level and pin slots
	localparam int FIXED_COUNT = 2;
	localparam logic [LEVEL_W-1:0] FIXED_LEVEL = 2'h3;
	localparam logic [LEVEL_W-1:0] FAST_LEVEL = 2'h2;
	localparam logic [SRC_W-1:0] SRC_PIN_A = 7'h02;
	localparam logic [SRC_W-1:0] SRC_PIN_B = 7'h03;

	// ==========================================================
	// reset values
	localparam logic [ADDR_W-1:0] INIT_ADDR_RST = 21'h0_0000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 21'h0_0000;
	localparam logic [SRC_W-1:0] SRC_RST = 7'h00;
	localparam logic [LEVEL_W-1:0] LEVEL_RST = 2'h0;

	// ==========================================================
	// one fast-interrupt channel
	typedef struct packed {
		logic [SRC_W-1:0] match;
		logic [FAST_HI_W-1:0] vec_high;
		logic [FAST_LO_W-1:0] vec_low;
	} fast_cfg_s;

	// external pin configuration
	typedef struct packed {
		logic edge_a;
		logic edge_b;
	} pin_cfg_s;
endpackage

// File: core/lowest_index_encoder.sv
// finds the lowest-numbered set bit of a request vector
`timescale 1ns/1ns
module lowest_index_encoder #(
	parameter int N = 82,
	parameter int W = 7
) (
	// requests
	input wire logic [N-1:0] req,
	// result
	output logic found,
	output logic [W-1:0] index
);
	always_comb begin
		found = 1'b0;
		index = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				found = 1'b1;
				index = W'(i);
			end
		end
	end
endmodule

// File: dv/core_model.sv
// processor core model that acknowledges the winning request
`timescale 1ns/1ns
module core_model
	import irq_arb_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// arbiter side
	input wire logic ack_en,
	input wire logic core_irq_ff,
	input wire logic [SRC_W-1:0] vec_num_ff,
	output logic irq_ack,
	output logic [SRC_W-1:0] ack_num
);
	// ==========================================================
	// ack logic
	// number is scrambled unless ack_en and core_irq_ff are both set, so nothing leans on a stale value
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_ack <= 1'h0;
			ack_num <= 7'h00;
		end else begin
			irq_ack <= ack_en & core_irq_ff & ~irq_ack;
			ack_num <= (ack_en & core_irq_ff) ? vec_num_ff : ~vec_num_ff;
		end
	end
endmodule

// File: dv/tb_priority_interrupt_arbiter.sv
// self-checking bench for the priority interrupt arbiter
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fail_count++; \
	$display("Error %s exp %h got %h", nm, ex, got); end end
module tb_priority_interrupt_arbiter;
	import irq_arb_pkg::*;
	// ==========================================================
	// stimulus and observation
	localparam logic [ADDR_W-1:0] BOOT = 21'h0_1234;
	logic ref_clk = 1'h0;
	logic reset_n = 1'h0;
	logic [NUM_SRC-1:0] irq_src = '0;
	logic [NUM_SRC-1:0] src_enable = '1;
	logic [NUM_SRC-1:0][LEVEL_W-1:0] src_level = {NUM_SRC{2'h1}};
	logic [BASE_W-1:0] vector_base = 14'h2a5c;
	fast_cfg_s fz = {7'h14, 5'h15, 16'hbeef};
	fast_cfg_s fo = {7'h14, 5'h0a, 16'h1234};
	pin_cfg_s pin_cfg = '0;
	logic pin_a_n = 1'h1;
	logic pin_b_n = 1'h1;
	logic [LEVEL_W-1:0] core_mask = '0;
	logic low_power = 1'h0;
	logic ack_en = 1'h0;
	logic irq_ack;
	logic [SRC_W-1:0] ack_num;
	logic core_irq_ff, fast_hit_ff, wake_ff, init_fetch_ff;
	logic [ADDR_W-1:0] vec_addr_ff, init_addr_ff;
	logic [SRC_W-1:0] vec_num_ff;
	logic [NUM_SRC-1:0] pending_ff;
	int fail_count = 0;
	int checks_done = 0;

	always #25 ref_clk = ~ref_clk;

	priority_interrupt_arbiter #(.INIT_ADDR(BOOT)) DUT (.ref_clk(ref_clk), .reset_n(reset_n),
		.irq_src(irq_src), .ext_irq_pin_a_n(pin_a_n), .ext_irq_pin_b_n(pin_b_n),
		.src_enable(src_enable), .src_level(src_level), .vector_base(vector_base),
		.fast_match_zero(fz), .fast_match_one(fo), .pin_cfg(pin_cfg), .core_mask(core_mask),
		.irq_ack(irq_ack), .ack_num(ack_num), .low_power(low_power),
		.core_irq_ff(core_irq_ff), .vec_addr_ff(vec_addr_ff), .vec_num_ff(vec_num_ff),
		.fast_hit_ff(fast_hit_ff), .pending_ff(pending_ff), .wake_ff(wake_ff),
		.init_fetch_ff(init_fetch_ff), .init_addr_ff(init_addr_ff));
	core_model core (.ref_clk(ref_clk), .reset_n(reset_n), .ack_en(ack_en),
		.core_irq_ff(core_irq_ff), .vec_num_ff(vec_num_ff), .irq_ack(irq_ack), .ack_num(ack_num));

	// ==========================================================
	// tasks
	function automatic logic [NUM_SRC-1:0] bit_of(input int i);
		return 82'h1 << i;
	endfunction

	function automatic logic [ADDR_W-1:0] nadr(input int n);
		return {vector_base, n[SRC_W-1:0]};
	endfunction

	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	task automatic expect_win(input logic [NUM_SRC-1:0] s, input logic [LEVEL_W-1:0] m,
		input logic irq, input int n, input logic [ADDR_W-1:0] a, input logic fh);
		@(posedge ref_clk);
		irq_src <= s;
		core_mask <= m;
		step(1);
		`CHK("core_irq", irq, core_irq_ff)
		if (irq) begin
			`CHK("vec_num", n[SRC_W-1:0], vec_num_ff)
			`CHK("vec_addr", a, vec_addr_ff)
			`CHK("fast_hit", fh, fast_hit_ff)
		end
	endtask

	// bounded wait for the core model to acknowledge a latched pin request
	task automatic ack_pending();
		@(posedge ref_clk);
		ack_en <= 1'h1;
		step(1);
		for (int i = 0; i <= 10 && core_irq_ff !== 1'h0; i++) begin
			if (i == 10) begin
				fail_count++;
				final_report();
			end
			step(1);
		end
		@(posedge ref_clk);
		ack_en <= 1'h0;
	endtask

	task automatic final_report();
		if (fail_count == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		src_level[10] <= 2'h3;
		src_level[20] <= 2'h2;
		src_level[40] <= 2'h0;
		step(20);
		`CHK("rst_irq", 1'h0, core_irq_ff)
		@(posedge ref_clk);
		reset_n <= 1'h1;
		step(1);
		`CHK("init_fetch", 1'h1, init_fetch_ff)
		`CHK("init_addr", BOOT, init_addr_ff)
		step(1);
		`CHK("init_fetch", 1'h0, init_fetch_ff)
		expect_win(bit_of(5) | bit_of(9) | bit_of(81), 2'h0, 1'h1, 5, nadr(5), 1'h0);
		expect_win(bit_of(81), 2'h0, 1'h1, 81, nadr(81), 1'h0);
		expect_win(bit_of(0) | bit_of(10) | bit_of(5), 2'h0, 1'h1, 0, nadr(0), 1'h0);
		expect_win(bit_of(10) | bit_of(4), 2'h0, 1'h1, 10, nadr(10), 1'h0);
		expect_win(bit_of(4), 2'h2, 1'h0, 4, nadr(4), 1'h0);
		expect_win(bit_of(10) | bit_of(4), 2'h2, 1'h1, 10, nadr(10), 1'h0);
		expect_win(bit_of(40), 2'h0, 1'h1, 40, nadr(40), 1'h0);
		expect_win(bit_of(40), 2'h1, 1'h0, 40, nadr(40), 1'h0);
		expect_win(bit_of(20), 2'h0, 1'h1, 20, {5'h15, 16'hbeef}, 1'h1);
		@(posedge ref_clk);
		fz.match <= 7'h04;
		expect_win(bit_of(20), 2'h0, 1'h1, 20, {5'h0a, 16'h1234}, 1'h1);
		expect_win(bit_of(4), 2'h0, 1'h1, 4, nadr(4), 1'h0);
		@(posedge ref_clk);
		src_enable[9] <= 1'h0;
		expect_win(bit_of(9) | bit_of(81), 2'h0, 1'h1, 81, nadr(81), 1'h0);
		`CHK("pending", bit_of(81), pending_ff)
		@(posedge ref_clk);
		low_power <= 1'h1;
		step(2);
		`CHK("wake", 1'h1, wake_ff)
		expect_win('0, 2'h0, 1'h0, 0, '0, 1'h0);
		step(1);
		`CHK("wake", 1'h0, wake_ff)
		@(posedge ref_clk);
		low_power <= 1'h0;
		pin_b_n <= 1'h0;
		step(2);
		`CHK("pin_b_num", 7'h03, vec_num_ff)
		@(posedge ref_clk);
		pin_b_n <= 1'h1;
		pin_cfg.edge_a <= 1'h1;
		pin_a_n <= 1'h0;
		step(2);
		`CHK("pin_a_num", 7'h02, vec_num_ff)
		ack_pending();
		step(2);
		`CHK("edge_held", 1'h0, core_irq_ff)
		@(posedge ref_clk);
		pin_cfg.edge_b <= 1'h1;
		pin_b_n <= 1'h0;
		step(2);
		`CHK("pin_b_edge", SRC_PIN_B, vec_num_ff)
		@(posedge ref_clk);
		pin_b_n <= 1'h1;
		step(2);
		`CHK("pin_b_latch", 1'h1, core_irq_ff)
		`CHK("pin_b_held", SRC_PIN_B, vec_num_ff)
		ack_pending();
		step(2);
		`CHK("pin_b_clear", 1'h0, core_irq_ff)
		@(posedge ref_clk);
		low_power <= 1'h1;
		step(2);
		`CHK("lp_level", 1'h1, core_irq_ff)
		`CHK("lp_num", 7'h02, vec_num_ff)
		`CHK("lp_wake", 1'h1, wake_ff)
		final_report();
	end
endmodule
